// ===== bench/apr_cfg_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "apr_defs.svh"

module apr_cfg_tb;
   // shortened settle count so the ready flag shows up quickly
   localparam int SETTLE = 20;

   logic                clk_i     = 1'b0;
   logic                rst_i     = 1'b1;
   logic                ce_i      = 1'b1;   // left running, freeze is not exercised
   logic                wb_cyc_i  = 1'b0;
   logic                wb_stb_i  = 1'b0;
   logic                wb_we_i   = 1'b0;
   logic [21:0]         wb_adr_i  = 22'h000000;
   logic [31:0]         wb_dat_i  = 32'h00000000;
   logic [3:0]          wb_sel_i  = 4'h0;
   logic [23:0]         pin_in_i  = 24'h81ff24;  // mixed levels in groups zero and fourteen, group two all high
   logic [31:0]         wb_dat_o;
   logic                wb_ack_o;
   logic [23:0]         pin_out_o;
   logic [23:0]         pin_oe_o;
   logic [23:0]         analog_input_o;
   logic [23:0]         prohibited_o;
   logic [2:0]          ref_generator_enable_o;
   logic                ground_source_select_o;
   logic                supply_source_select_o;
   logic                ref_ready_o;
   logic                amplifier_enable_o;
   apr_pkg::apr_gain_t  amplifier_gain_o;
   logic [2:0]          amplifier_input_select_o;
   logic                analog_unit_reset_o;
   int                  bad_count   = 0;
   int                  comparisons = 0;

   apr_cfg #(.REF_SETTLE_CYC(SETTLE)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in_i(pin_in_i),
      .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .analog_input_o(analog_input_o),
      .prohibited_o(prohibited_o), .ref_generator_enable_o(ref_generator_enable_o),
      .ground_source_select_o(ground_source_select_o),
      .supply_source_select_o(supply_source_select_o), .ref_ready_o(ref_ready_o),
      .amplifier_enable_o(amplifier_enable_o), .amplifier_gain_o(amplifier_gain_o),
      .amplifier_input_select_o(amplifier_input_select_o),
      .analog_unit_reset_o(analog_unit_reset_o)
   );

   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;

   // verdict and end of run, shared by main sequence and watchdog
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // compare seen against expected, four-state exact
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t value %h expected %h", $time, seen, exp);
      end
   endtask

   // one classic cycle; request held until ack is sampled high, for at most 20 edges
   task automatic bus(input logic we, input logic [19:0] idx, input logic [7:0] d,
                      input logic [3:0] sel, output logic [7:0] q);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h000000, d};
      wb_sel_i <= sel;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         bad_count++;
         $display("FAIL t=%0t no bus answer", $time);
      end
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      // strobe stays low for one full cycle
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [19:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, 4'h1, q);
   endtask

   task automatic rd(input logic [19:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, idx, 8'h00, 4'h1, q);
      check({16'h0000, q}, {16'h0000, exp});
   endtask

   // reset held five cycles, then two edges for the decode to load
   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   // watchdog, generous against roughly two hundred cycles of tests
   initial begin
      repeat (5000) @(posedge clk_i);
      bad_count++;
      $display("FAIL t=%0t watchdog expired", $time);
      results();
   end

   initial begin
      logic [7:0] q;
      do_reset();
      // reset state and decode of default selections
      rd(`APR_IDX_DIR_G0, 8'hff);
      rd(`APR_IDX_DIR_G2, 8'hff);
      rd(`APR_IDX_DIR_G14, 8'hff);
      rd(`APR_IDX_REF_CTL, 8'h00);
      check(analog_input_o, 24'h80ff0c);
      check(pin_oe_o, 24'h000000);
      check({23'h0, analog_unit_reset_o}, 24'h000001);
      rd(`APR_IDX_DAT_G2, 8'h00);
      rd(`APR_IDX_DAT_G0, 8'h20);
      // all directions to output while analog is still selected, fixed bits kept at one
      wr(`APR_IDX_DIR_G0, 8'h93);
      wr(`APR_IDX_DIR_G2, 8'h08);
      wr(`APR_IDX_DIR_G14, 8'h7f);
      rd(`APR_IDX_DIR_G0, 8'h93);
      rd(`APR_IDX_DIR_G2, 8'h08);
      rd(`APR_IDX_DIR_G14, 8'h7f);
      check(pin_oe_o, 24'h000060);
      check(prohibited_o, 24'h80f70c);
      check(analog_input_o, 24'h000800);
      // single bit set done as read-modify-write
      bus(1'b0, `APR_IDX_DIR_G2, 8'h00, 4'h1, q);
      wr(`APR_IDX_DIR_G2, q | 8'h04);
      rd(`APR_IDX_DIR_G2, 8'h0c);
      check(analog_input_o[15:8], 8'h0c);
      // switch everything to digital
      wr(`APR_IDX_AD_SEL, 8'h01);
      wr(`APR_IDX_DIR_G2, 8'h08);
      wr(`APR_IDX_DAT_G2, 8'ha5);
      wr(`APR_IDX_AN_G0, 8'h00);
      wr(`APR_IDX_AN_G14, 8'h00);
      rd(`APR_IDX_AN_G0, 8'hf3);
      rd(`APR_IDX_AN_G14, 8'h7f);
      check(pin_oe_o, 24'h80f76c);
      check(prohibited_o, 24'h000000);
      check(pin_out_o[15:8], 8'ha5);
      rd(`APR_IDX_DAT_G2, 8'had);
      // unmapped place and disabled byte lane
      wr(20'h12345, 8'hff);
      rd(20'h12345, 8'h00);
      bus(1'b1, `APR_IDX_DIR_G0, 8'hff, 4'h0, q);
      rd(`APR_IDX_DIR_G0, 8'h93);
      // reference control, first with the unit clock off
      wr(`APR_IDX_REF_CTL, 8'h37);
      rd(`APR_IDX_REF_CTL, 8'h00);
      check({21'h0, ref_generator_enable_o}, 24'h000000);
      wr(`APR_IDX_UNIT_EN, 8'h80);
      check({23'h0, analog_unit_reset_o}, 24'h000000);
      wr(`APR_IDX_REF_CTL, 8'hff);
      rd(`APR_IDX_REF_CTL, 8'h37);
      check({ground_source_select_o, supply_source_select_o}, 24'h000003);
      check({21'h0, ref_generator_enable_o}, 24'h000007);
      check({23'h0, ref_ready_o}, 24'h000000);
      repeat (SETTLE + 10) @(posedge clk_i);
      check({23'h0, ref_ready_o}, 24'h000001);
      rd(`APR_IDX_REF_STAT, 8'h01);
      // generators stopped first, then the sources changed
      wr(`APR_IDX_REF_CTL, 8'h30);
      wr(`APR_IDX_REF_CTL, 8'h00);
      for (int m = 0; m < 3; m++) begin
         wr(`APR_IDX_REF_CTL, 8'h01 << m);
         check({21'h0, ref_generator_enable_o}, 24'h000001 << m);
         check({ground_source_select_o, supply_source_select_o}, 24'h000000);
      end
      // amplifier fields, then the start order with every gain
      wr(`APR_IDX_AMP_CTL, 8'h7f);
      rd(`APR_IDX_AMP_CTL, 8'h37);
      wr(`APR_IDX_AMP_CTL, 8'h00);
      // pins analog and input before the amplifier is set up
      wr(`APR_IDX_AD_SEL, 8'h00);
      wr(`APR_IDX_DIR_G2, 8'hff);
      check(analog_input_o[15:8], 8'hff);
      for (int g = 0; g < 4; g++) begin
         wr(`APR_IDX_AMP_CTL, {2'b00, 2'(g), 4'h2});
         check({22'h0, amplifier_gain_o}, 24'(g));
         check({21'h0, amplifier_input_select_o}, 24'h000002);
      end
      wr(`APR_IDX_AMP_CTL, 8'hb2);
      rd(`APR_IDX_AMP_CTL, 8'hb2);
      check({23'h0, amplifier_enable_o}, 24'h000001);
      // unit clock off holds both units in reset
      wr(`APR_IDX_UNIT_EN, 8'h00);
      check({21'h0, ref_generator_enable_o}, 24'h000000);
      check({23'h0, amplifier_enable_o}, 24'h000000);
      rd(`APR_IDX_AMP_CTL, 8'h00);
      // second reset in mid-run
      do_reset();
      rd(`APR_IDX_DIR_G2, 8'hff);
      rd(`APR_IDX_REF_CTL, 8'h00);
      results();
   end
endmodule

`default_nettype wire

// ===== src/apr_cfg.sv
`timescale 1ns/1ps
`default_nettype none
`include "apr_defs.svh"

// Functional notes
// - output direction never gives analog input
// - direction registers reset to all ones
// - analog pins read zero as port data
// - direction zero output, one input
// - group two pins four-way function decode
// - groups zero, fourteen same four-way decode
// - byte writes accepted, low lane only
// - reference control resets to zero
// - reference control field layout, zeros fixed
// - ground select chip ground or reference
// - supply select main supply or reference
// - generator enable stops or runs generator
// - amplifier gain four choices x4..x32
// - amplifier input pin, output to converter
// - unit clock off blocks ref and amp control writes, holds reset
module apr_cfg #(
   parameter int REF_SETTLE_CYC = `APR_REF_SETTLE_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [21:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   input  wire logic [23:0] pin_in_i,
   output var  logic [23:0] pin_out_o,
   output var  logic [23:0] pin_oe_o,
   output var  logic [23:0] analog_input_o,
   output var  logic [23:0] prohibited_o,
   output var  logic [2:0]  ref_generator_enable_o,
   output var  logic        ground_source_select_o,
   output var  logic        supply_source_select_o,
   output var  logic        ref_ready_o,
   output var  logic        amplifier_enable_o,
   output var  apr_pkg::apr_gain_t amplifier_gain_o,
   output var  logic [2:0]  amplifier_input_select_o,
   output var  logic        analog_unit_reset_o
);

   localparam int CW = $clog2(REF_SETTLE_CYC + 1);   // settle counter width

   // register state
   logic [7:0]  dir_g0;            // port_direction_group_zero
   logic [7:0]  dir_g2;            // port_direction_group_two
   logic [7:0]  dir_g14;           // port_direction_group_fourteen
   logic [7:0]  dat_g0;            // output latches, group zero
   logic [7:0]  dat_g2;            // output latches, group two
   logic [7:0]  dat_g14;           // output latches, group fourteen
   logic [7:0]  an_g0;             // analog_select_group_zero
   logic [7:0]  an_g14;            // analog_select_group_fourteen
   logic [3:0]  ad_sel;            // analog_digital_group_select
   logic [7:0]  ref_ctl;           // ref_voltage_control
   logic [7:0]  amp_ctl;           // amplifier control
   logic        unit_en;           // analog_unit_clock_enable
   logic [CW-1:0] ref_cnt;         // cycles since enables last changed
   logic [7:0]  next_dir_g0;
   logic [7:0]  next_dir_g2;
   logic [7:0]  next_dir_g14;
   logic [7:0]  next_dat_g0;
   logic [7:0]  next_dat_g2;
   logic [7:0]  next_dat_g14;
   logic [7:0]  next_an_g0;
   logic [7:0]  next_an_g14;
   logic [3:0]  next_ad_sel;
   logic [7:0]  next_ref_ctl;
   logic [7:0]  next_amp_ctl;
   logic        next_unit_en;
   logic [CW-1:0] next_ref_cnt;
   logic [31:0] next_dat_o;
   logic        next_ack;
   logic        next_ref_ready;    // settle count reached
   logic        next_unit_rst;     // analog units held in reset next cycle

   // bus decode
   logic        taken;             // request accepted this cycle
   logic        wr_byte;           // write with low lane enabled
   logic [19:0] idx;               // register index
   logic [7:0]  wdata;             // low byte of write data
   logic [7:0]  rd_byte;           // read mux result

   // pin vectors, group zero low, fourteen high
   logic [23:0] dir_all;
   logic [23:0] latch_all;
   logic [23:0] an_all;
   logic [23:0] oe_d;
   logic [23:0] ana_d;
   logic [23:0] pro_d;
   logic [23:0] rd_d;

   // analog pins of group two from the group select code
   function automatic logic [7:0] ad_mask(input logic [3:0] v);
      logic [7:0] m;
      m = 8'h00;
      if (v == 4'h0 || v == 4'hf) begin
         m = 8'hff;
      end else if (v >= 4'h2 && v <= 4'h9) begin
         m = 8'((9'h001 << (v - 4'h1)) - 9'h001);
      end
      return m;   // prohibited codes fall back to all digital
   endfunction

   // pin vectors for the decoder
   always_comb begin
      dir_all   = {dir_g14, dir_g2, dir_g0};
      latch_all = {dat_g14, dat_g2, dat_g0};
      an_all    = {an_g14 & `APR_CAP_G14, ad_mask(ad_sel), an_g0 & `APR_CAP_G0};
   end

   apr_pin_decode #(
      .N (24)
   ) u_decode (
      .analog_sel_i (an_all),
      .dir_i        (dir_all),
      .latch_i      (latch_all),
      .pin_in_i     (pin_in_i),
      .oe_o         (oe_d),
      .analog_o     (ana_d),
      .prohib_o     (pro_d),
      .port_rd_o    (rd_d)
   );

   // next register values and bus answer
   always_comb begin
      taken   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wr_byte = taken & wb_we_i & wb_sel_i[0];
      idx     = wb_adr_i[21:2];
      wdata   = wb_dat_i[7:0];
      next_dir_g0  = dir_g0;
      next_dir_g2  = dir_g2;
      next_dir_g14 = dir_g14;
      next_dat_g0  = dat_g0;
      next_dat_g2  = dat_g2;
      next_dat_g14 = dat_g14;
      next_an_g0   = an_g0;
      next_an_g14  = an_g14;
      next_ad_sel  = ad_sel;
      next_ref_ctl = ref_ctl;
      next_amp_ctl = amp_ctl;
      next_unit_en = unit_en;
      // writes; fixed-one and fixed-zero bits are forced into the stored value
      if (wr_byte) begin
         case (idx)
            `APR_IDX_DIR_G0:  next_dir_g0  = wdata | ~`APR_IMPL_G0;
            `APR_IDX_DIR_G2:  next_dir_g2  = wdata | ~`APR_IMPL_G2;
            `APR_IDX_DIR_G14: next_dir_g14 = wdata | ~`APR_IMPL_G14;
            `APR_IDX_DAT_G0:  next_dat_g0  = wdata;
            `APR_IDX_DAT_G2:  next_dat_g2  = wdata;
            `APR_IDX_DAT_G14: next_dat_g14 = wdata;
            `APR_IDX_AN_G0:   next_an_g0   = wdata | ~`APR_CAP_G0;
            `APR_IDX_AN_G14:  next_an_g14  = wdata | ~`APR_CAP_G14;
            `APR_IDX_AD_SEL:  next_ad_sel  = wdata[3:0];
            `APR_IDX_REF_CTL: next_ref_ctl = wdata & `APR_REF_MASK;
            `APR_IDX_AMP_CTL: next_amp_ctl = wdata & `APR_AMP_MASK;
            `APR_IDX_UNIT_EN: next_unit_en = wdata[`APR_UNIT_EN_BIT];
            default: ;                               // unmapped writes are dropped
         endcase
      end
      // unit clock off: reference and amplifier control writes blocked and both held in reset
      if (!unit_en) begin
         next_ref_ctl = `APR_RST_REF;
         next_amp_ctl = `APR_RST_AMP;
      end
      // settle counter restarts whenever any enable changes
      if (next_ref_ctl[2:0] != ref_ctl[2:0] || ref_ctl[2:0] == 3'b000) begin
         next_ref_cnt = '0;
      end else if (ref_cnt != CW'(REF_SETTLE_CYC)) begin
         next_ref_cnt = ref_cnt + CW'(1);
      end else begin
         next_ref_cnt = ref_cnt;
      end
      // read mux, unmapped reads give zero
      case (idx)
         `APR_IDX_DIR_G0:   rd_byte = dir_g0;
         `APR_IDX_DIR_G2:   rd_byte = dir_g2;
         `APR_IDX_DIR_G14:  rd_byte = dir_g14;
         `APR_IDX_DAT_G0:   rd_byte = rd_d[7:0];
         `APR_IDX_DAT_G2:   rd_byte = rd_d[15:8];
         `APR_IDX_DAT_G14:  rd_byte = rd_d[23:16];
         `APR_IDX_AN_G0:    rd_byte = an_g0;
         `APR_IDX_AN_G14:   rd_byte = an_g14;
         `APR_IDX_AD_SEL:   rd_byte = {4'h0, ad_sel};
         `APR_IDX_REF_CTL:  rd_byte = ref_ctl;
         `APR_IDX_REF_STAT: rd_byte = {7'h00, ref_ready_o};
         `APR_IDX_AMP_CTL:  rd_byte = amp_ctl;
         `APR_IDX_UNIT_EN:  rd_byte = {unit_en, 7'h00};
         default:           rd_byte = 8'h00;
      endcase
      next_ack   = taken;
      next_dat_o = taken ? {24'h000000, rd_byte} : wb_dat_o;
      // ready and unit reset are registered so both outputs leave a flop
      next_ref_ready = (next_ref_cnt == CW'(REF_SETTLE_CYC));
      next_unit_rst  = ~next_unit_en;
   end

   // registers; everything freezes while the clock enable is low
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dir_g0   <= `APR_RST_DIR;
         dir_g2   <= `APR_RST_DIR;
         dir_g14  <= `APR_RST_DIR;
         dat_g0   <= `APR_RST_DAT;
         dat_g2   <= `APR_RST_DAT;
         dat_g14  <= `APR_RST_DAT;
         an_g0    <= `APR_RST_AN_SEL;
         an_g14   <= `APR_RST_AN_SEL;
         ad_sel   <= `APR_RST_AD_SEL;
         ref_ctl  <= `APR_RST_REF;
         amp_ctl  <= `APR_RST_AMP;
         unit_en  <= 1'b0;
         ref_cnt  <= '0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         pin_out_o      <= 24'h000000;
         pin_oe_o       <= 24'h000000;
         analog_input_o <= 24'h000000;
         prohibited_o   <= 24'h000000;
         ref_ready_o    <= 1'b0;
         analog_unit_reset_o <= 1'b1;
      end else if (ce_i) begin
         dir_g0   <= next_dir_g0;
         dir_g2   <= next_dir_g2;
         dir_g14  <= next_dir_g14;
         dat_g0   <= next_dat_g0;
         dat_g2   <= next_dat_g2;
         dat_g14  <= next_dat_g14;
         an_g0    <= next_an_g0;
         an_g14   <= next_an_g14;
         ad_sel   <= next_ad_sel;
         ref_ctl  <= next_ref_ctl;
         amp_ctl  <= next_amp_ctl;
         unit_en  <= next_unit_en;
         ref_cnt  <= next_ref_cnt;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat_o;
         // pin outputs lag the registers by one cycle, kept glitch free
         pin_out_o      <= latch_all;
         pin_oe_o       <= oe_d;
         analog_input_o <= ana_d;
         prohibited_o   <= pro_d;
         ref_ready_o    <= next_ref_ready;
         // same timing as the enable bit itself, no extra lag
         analog_unit_reset_o <= next_unit_rst;
      end
   end

   // reference and amplifier controls straight from their registers
   always_comb begin
      ref_generator_enable_o   = ref_ctl[2:0];
      ground_source_select_o   = ref_ctl[`APR_REF_GND_BIT];
      supply_source_select_o   = ref_ctl[`APR_REF_SUP_BIT];
      amplifier_enable_o       = amp_ctl[`APR_AMP_EN_BIT];
      amplifier_gain_o         = apr_pkg::apr_gain_t'(amp_ctl[`APR_AMP_GAIN_LSB +: 2]);
      amplifier_input_select_o = amp_ctl[2:0];
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_dir0_write;
      ce_i && wr_byte && idx == `APR_IDX_DIR_G0;
   endsequence

   sequence s_port0_read;
      ce_i && taken && !wb_we_i && idx == `APR_IDX_DAT_G0;
   endsequence

   a_fixed_dir_ones: assert property (&(dir_g0 | `APR_IMPL_G0) && &(dir_g2 | `APR_IMPL_G2)
                                      && &(dir_g14 | `APR_IMPL_G14))
      else $error("fixed direction bit reads zero");
   a_ref_fixed_zero: assert property ((ref_ctl & ~`APR_REF_MASK) == 8'h00)
      else $error("fixed-zero reference bit set");
   a_unit_gate_hold: assert property (ce_i && !unit_en |=> ref_ctl == 8'h00 && amp_ctl == 8'h00)
      else $error("gated analog registers not held in reset");
   a_dir_byte_write: assert property (s_dir0_write |=> dir_g0 == ($past(wb_dat_i[7:0]) | 8'h93))
      else $error("direction write did not land");
   a_port_analog_zero: assert property (s_port0_read |=> (wb_dat_o[7:0] & $past(ana_d[7:0])) == 8'h00)
      else $error("analog pin read nonzero");
   a_no_analog_out: assert property ((analog_input_o & pin_oe_o) == 24'h000000)
      else $error("pin both analog and driven");
   // the release edge still resets the pin flops, so no attempt starts there
   a_oe_from_dir: assert property (ce_i && !rst_i |=>
                                   pin_oe_o == (~$past(dir_all) & ~$past(an_all)))
      else $error("output enable does not follow direction");
   a_analog_decode: assert property (ce_i && !rst_i |=>
                                     analog_input_o == ($past(an_all) & $past(dir_all)))
      else $error("analog input decode wrong");
   a_prohib_decode: assert property (ce_i && !rst_i |=>
                                     prohibited_o == ($past(an_all) & ~$past(dir_all)))
      else $error("prohibited decode wrong");

endmodule

`default_nettype wire

// ===== src/apr_defs.svh
`ifndef APR_DEFS_SVH
`define APR_DEFS_SVH

// register indices, byte address is four times the index
`define APR_IDX_REF_CTL     20'he0560
`define APR_IDX_REF_STAT    20'he0561
`define APR_IDX_AMP_CTL     20'he0570
`define APR_IDX_AN_G0       20'hf0060
`define APR_IDX_AN_G14      20'hf006e
`define APR_IDX_AD_SEL      20'hf0076
`define APR_IDX_UNIT_EN     20'hf00fc
`define APR_IDX_DAT_G0      20'hfff00
`define APR_IDX_DAT_G2      20'hfff02
`define APR_IDX_DAT_G14     20'hfff0e
`define APR_IDX_DIR_G0      20'hfff20
`define APR_IDX_DIR_G2      20'hfff22
`define APR_IDX_DIR_G14     20'hfff2e

// reset values
`define APR_RST_DIR         8'hff
`define APR_RST_REF         8'h00
`define APR_RST_AMP         8'h00
`define APR_RST_AN_SEL      8'hff
`define APR_RST_AD_SEL      4'h0
`define APR_RST_DAT         8'h00

// implemented direction bits per group, the rest are fixed at one
`define APR_IMPL_G0         8'h6c
`define APR_IMPL_G2         8'hf7
`define APR_IMPL_G14        8'h80
// analog-capable pins of groups zero and fourteen
`define APR_CAP_G0          8'h0c
`define APR_CAP_G14         8'h80

// writable bits of control registers
`define APR_REF_MASK        8'h37
`define APR_AMP_MASK        8'hb7

// field positions
`define APR_REF_GND_BIT     5
`define APR_REF_SUP_BIT     4
`define APR_AMP_EN_BIT      7
`define APR_AMP_GAIN_LSB    4
`define APR_UNIT_EN_BIT     7

// reference settling time
`define APR_REF_SETTLE_US   10
`define APR_CLK_MHZ         200
`define APR_REF_SETTLE_CYC  (`APR_REF_SETTLE_US * `APR_CLK_MHZ)

`endif

// ===== src/apr_pin_decode.sv
`timescale 1ns/1ps
`default_nettype none

module apr_pin_decode #(
   parameter int N = 24
) (
   input  wire logic [N-1:0] analog_sel_i,  // per-pin analog selection
   input  wire logic [N-1:0] dir_i,         // per-pin direction, one is input
   input  wire logic [N-1:0] latch_i,       // output latch values
   input  wire logic [N-1:0] pin_in_i,      // pin levels
   output var  logic [N-1:0] oe_o,          // output buffer on
   output var  logic [N-1:0] analog_o,      // pin serves as analog input
   output var  logic [N-1:0] prohib_o,      // prohibited combination
   output var  logic [N-1:0] port_rd_o      // value seen by a port data read
);

   for (genvar i = 0; i < N; i++) begin : g_pin
      apr_pkg::apr_pin_func_t func;   // decoded function of this pin

      // four-way decode of selection and direction
      always_comb begin
         unique case ({analog_sel_i[i], dir_i[i]})
            2'b01: func = apr_pkg::APR_DIG_IN;
            2'b00: func = apr_pkg::APR_DIG_OUT;
            2'b11: func = apr_pkg::APR_ANA_IN;
            2'b10: func = apr_pkg::APR_PROHIB;
         endcase
      end

      // buffer on only for digital output; prohibited keeps it off as the safe side
      always_comb oe_o[i] = (func == apr_pkg::APR_DIG_OUT);
      // output direction never yields analog input
      always_comb analog_o[i] = (func == apr_pkg::APR_ANA_IN);
      always_comb prohib_o[i] = (func == apr_pkg::APR_PROHIB);

      // analog pins read as zero, outputs read back the latch
      always_comb begin
         unique case (func)
            apr_pkg::APR_DIG_IN:  port_rd_o[i] = pin_in_i[i];
            apr_pkg::APR_DIG_OUT: port_rd_o[i] = latch_i[i];
            apr_pkg::APR_ANA_IN:  port_rd_o[i] = 1'b0;
            apr_pkg::APR_PROHIB:  port_rd_o[i] = 1'b0;
         endcase
      end
   end

endmodule

`default_nettype wire

// ===== src/apr_pkg.sv
package apr_pkg;

   // function of one pin after decode
   typedef enum logic [1:0] {
      APR_DIG_IN  = 2'b00,
      APR_DIG_OUT = 2'b01,
      APR_ANA_IN  = 2'b10,
      APR_PROHIB  = 2'b11
   } apr_pin_func_t;

   // amplifier gain code
   typedef enum logic [1:0] {
      APR_GAIN_X4  = 2'b00,
      APR_GAIN_X8  = 2'b01,
      APR_GAIN_X16 = 2'b10,
      APR_GAIN_X32 = 2'b11
   } apr_gain_t;

endpackage
